// File: verilog/led_cfg.svh
// Register map, field positions, reset values and timing for LED logic
`ifndef LED_CFG_SVH
`define LED_CFG_SVH

// Register byte offsets
`define LED_OFF_MODE0   8'h00
`define LED_OFF_MODE1   8'h04
`define LED_OFF_MODE2   8'h08
`define LED_OFF_MODE3   8'h0c
`define LED_OFF_BEHAV   8'h10
`define LED_OFF_DRIVE   8'h14
`define LED_OFF_STAT    8'h18

// Field positions
`define LED_BH_RATE_LSB 16
`define LED_BH_SPLIT    18
`define LED_BH_BOOT     19
`define LED_DR_STYLE    4
`define LED_ST_BOOT     16

// Reset values
`define LED_MODE_RST    16'h8210
`define LED_BEHAV_RST   20'h80000
`define LED_DRIVE_RST   5'h10

// Timing
`define SERIAL_INDICATOR_CLOCK_NS      10
`define LED_NS_PER_MS   1000000
`define LED_UNIT_MS     25
`define LED_BOOT_MS     1000
`define LED_SER_HALF_NS 500

`endif

// File: verilog/led_pkg.sv
// Types shared by the LED indicator modules
package led_pkg;

	// Display function codes of one LED
	typedef enum logic [3:0] {
		MODE_LINK_ANY  = 4'h0,
		MODE_LINK_1G   = 4'h1,
		MODE_LINK_100  = 4'h2,
		MODE_LINK_10   = 4'h3,
		MODE_LINK_FAST = 4'h4,
		MODE_LINK_10G  = 4'h5,
		MODE_LINK_SLOW = 4'h6,
		MODE_LINK_FIB  = 4'h7,
		MODE_DUPLEX    = 4'h8,
		MODE_COLL      = 4'h9,
		MODE_ACT       = 4'ha,
		MODE_FIB_ACT   = 4'hb,
		MODE_AN_FAULT  = 4'hc,
		MODE_SERIAL    = 4'hd,
		MODE_OFF       = 4'he,
		MODE_ON        = 4'hf
	} led_mode_t;

	// Serial stream sequencer
	typedef enum logic [0:0] {
		SER_IDLE  = 1'b0,
		SER_SHIFT = 1'b1
	} ser_state_t;

endpackage : led_pkg

// File: verilog/led_tick_gen.sv
// Time base: 25 ms tick, blink phases and after-reset window
`timescale 1ns/10ps
module led_tick_gen #(
	parameter int UNIT_CYC   = 2500000,
	parameter int BOOT_UNITS = 40
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// Time base
	output logic            unit_tick,
	output logic [3:0]      phase,
	output logic            boot
);
	localparam int CW = $clog2(UNIT_CYC);
	localparam int BW = $clog2(BOOT_UNITS + 1);

	logic [CW-1:0] cyc_ff, nxt_cyc_ff;
	logic          tick_ff, nxt_tick_ff;
	logic [3:0]    phase_ff, nxt_phase_ff;
	logic [BW-1:0] boot_ff, nxt_boot_ff;

	if (UNIT_CYC < 2 || BOOT_UNITS < 1) begin : g_chk
		$error("led_tick_gen: counts too small");
	end

	// Phase bit k toggles every 2^k units: 20, 10, 5, 2.5 Hz
	always_comb begin
		nxt_tick_ff = 1'b0;
		nxt_cyc_ff = cyc_ff + 1'b1;
		nxt_phase_ff = phase_ff;
		nxt_boot_ff = boot_ff;
		if (cyc_ff == CW'(UNIT_CYC - 1)) begin
			nxt_cyc_ff = '0;
			nxt_tick_ff = 1'b1;
			nxt_phase_ff = phase_ff + 4'h1;
			if (boot_ff != '0) begin
				nxt_boot_ff = boot_ff - 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cyc_ff <= '0;
			tick_ff <= 1'b0;
			phase_ff <= 4'h0;
			boot_ff <= BW'(BOOT_UNITS);
		end else begin
			cyc_ff <= nxt_cyc_ff;
			tick_ff <= nxt_tick_ff;
			phase_ff <= nxt_phase_ff;
			boot_ff <= nxt_boot_ff;
		end
	end

	assign unit_tick = tick_ff;
	assign phase     = phase_ff;
	assign boot      = (boot_ff != '0);

endmodule : led_tick_gen

// File: verilog/led_serial_tx.sv
// 48-bit serial status stream, data changes on falling clock
`timescale 1ns/10ps
module led_serial_tx #(
	parameter int HALF_CYC = 50
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// Status snapshot
	input  wire logic        en,
	input  wire logic [47:0] frame,
	// Stream pins
	output logic             sdata,
	output logic             sclk
);
	localparam int HW = $clog2(HALF_CYC + 1);

	led_pkg::ser_state_t st_ff, nxt_st_ff;
	logic [HW-1:0] half_ff, nxt_half_ff;
	logic [47:0]   sh_ff, nxt_sh_ff;
	logic [5:0]    bit_ff, nxt_bit_ff;
	logic          clk_ff, nxt_clk_ff;

	if (HALF_CYC < 1) begin : g_chk
		$error("led_serial_tx: HALF_CYC must be at least 1");
	end

	// Frames repeat back to back; snapshot taken at frame start
	always_comb begin
		nxt_st_ff = st_ff;
		nxt_half_ff = half_ff;
		nxt_sh_ff = sh_ff;
		nxt_bit_ff = bit_ff;
		nxt_clk_ff = clk_ff;
		unique case (st_ff)
			led_pkg::SER_IDLE: begin
				nxt_clk_ff = 1'b0;
				if (en) begin
					nxt_st_ff = led_pkg::SER_SHIFT;
					nxt_sh_ff = frame;
					nxt_bit_ff = 6'h00;
					nxt_half_ff = '0;
				end
			end
			led_pkg::SER_SHIFT: begin
				nxt_half_ff = half_ff + 1'b1;
				if (!en) begin
					nxt_st_ff = led_pkg::SER_IDLE;
					nxt_clk_ff = 1'b0;
				end else if (half_ff == HW'(HALF_CYC - 1)) begin
					nxt_half_ff = '0;
					nxt_clk_ff = ~clk_ff;
					if (clk_ff) begin
						if (bit_ff == 6'h2f) begin
							nxt_bit_ff = 6'h00;
							nxt_sh_ff = frame;
						end else begin
							nxt_bit_ff = bit_ff + 6'h01;
							nxt_sh_ff = {1'b0, sh_ff[47:1]};
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= led_pkg::SER_IDLE;
			half_ff <= '0;
			sh_ff <= 48'h0;
			bit_ff <= 6'h00;
			clk_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st_ff;
			half_ff <= nxt_half_ff;
			sh_ff <= nxt_sh_ff;
			bit_ff <= nxt_bit_ff;
			clk_ff <= nxt_clk_ff;
		end
	end

	assign sdata = sh_ff[0];
	assign sclk  = clk_ff;

endmodule : led_serial_tx

// File: verilog/led_status_indicator.sv
// Four-port LED status indicator: mode decode, stretch, drive, registers
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "led_cfg.svh"
module led_status_indicator #(
	parameter int UNIT_CYC =
		`LED_UNIT_MS * `LED_NS_PER_MS / `SERIAL_INDICATOR_CLOCK_NS,
	parameter int SER_HALF_CYC = `LED_SER_HALF_NS / `SERIAL_INDICATOR_CLOCK_NS
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Link status, bit n belongs to port n
	input  wire logic [3:0]  link_1g_cu,
	input  wire logic [3:0]  link_1g_fi,
	input  wire logic [3:0]  link_100_cu,
	input  wire logic [3:0]  link_100_fi,
	input  wire logic [3:0]  link_10_cu,
	input  wire logic [3:0]  full_duplex,
	input  wire logic [3:0]  collision,
	input  wire logic [3:0]  tx_act,
	input  wire logic [3:0]  rx_act,
	input  wire logic [3:0]  an_fault,
	// LED pins, index port*4 + led
	output logic      [15:0] led_out,
	output logic      [15:0] led_oe_n
);
	localparam int BOOT_UNITS = `LED_BOOT_MS / `LED_UNIT_MS;

	if (UNIT_CYC < 2 || SER_HALF_CYC < 1) begin : g_chk
		$error("led_status_indicator: counts too small");
	end

	// Activity source of an LED for its mode
	function automatic logic act_src(
		input led_pkg::led_mode_t m,
		input logic split,
		input logic tx,
		input logic rx,
		input logic cl,
		input logic fib
	);
		case (m)
			led_pkg::MODE_DUPLEX,
			led_pkg::MODE_COLL:    act_src = cl;
			led_pkg::MODE_ACT:     act_src = split ? tx : (tx | rx);
			led_pkg::MODE_FIB_ACT:
				act_src = split ? rx : ((tx | rx) & fib);
			default:               act_src = tx | rx;
		endcase
	endfunction : act_src

	// Logical state; lk = {10cu, 100fi, 100cu, 1gfi, 1gcu}
	function automatic logic eval(
		input led_pkg::led_mode_t m,
		input logic [4:0] lk,
		input logic fd,
		input logic anf,
		input logic on,
		input logic str,
		input logic ph
	);
		logic pat_l;
		logic pat_a;
		// Stretch shows as an off window on link modes
		pat_l = on ? (str ? 1'b0 : ph) : 1'b1;
		pat_a = on & (str | ph);
		case (m)
			led_pkg::MODE_LINK_ANY:  eval = (|lk) & pat_l;
			led_pkg::MODE_LINK_1G:
				eval = (lk[0] | lk[1]) & pat_l;
			led_pkg::MODE_LINK_100:
				eval = (lk[2] | lk[3]) & pat_l;
			led_pkg::MODE_LINK_10:   eval = lk[4] & pat_l;
			led_pkg::MODE_LINK_FAST:
				eval = (|lk[3:0]) & pat_l;
			led_pkg::MODE_LINK_10G:
				eval = (lk[4] | lk[1] | lk[0]) & pat_l;
			led_pkg::MODE_LINK_SLOW:
				eval = (lk[4] | lk[3] | lk[2]) & pat_l;
			led_pkg::MODE_LINK_FIB:
				eval = (lk[3] | lk[1]) & pat_l;
			led_pkg::MODE_DUPLEX:
				eval = (|lk) & (fd | pat_a);
			led_pkg::MODE_COLL,
			led_pkg::MODE_ACT,
			led_pkg::MODE_FIB_ACT:   eval = pat_a;
			led_pkg::MODE_AN_FAULT:  eval = anf;
			led_pkg::MODE_ON:        eval = 1'b1;
			default:                 eval = 1'b0;
		endcase
	endfunction : eval

	// Register state
	logic [15:0] mode_ff [4];
	logic [15:0] nxt_mode_ff [4];
	logic [19:0] behav_ff, nxt_behav_ff;
	logic [4:0]  drive_ff, nxt_drive_ff;
	logic [31:0] rdata_ff, nxt_rdata_ff;

	// LED state
	logic [4:0]  cnt_ff [16];
	logic [4:0]  nxt_cnt_ff [16];
	logic [15:0] state_ff, nxt_state_ff;
	logic [15:0] out_ff, nxt_out_ff;
	logic [15:0] oe_n_ff, nxt_oe_n_ff;

	// Decoded per LED
	led_pkg::led_mode_t md [16];
	logic [15:0] src;
	logic [15:0] str_sel;
	logic [4:0]  lk [4];
	logic [3:0]  fib;
	logic [1:0]  rate;
	logic        split;
	logic        ser_en;
	logic [47:0] ser_frame;

	// Time base and stream
	logic        unit_tick;
	logic [3:0]  phase;
	logic        boot;
	logic        ser_data;
	logic        ser_clk;

	led_tick_gen #(
		.UNIT_CYC   (UNIT_CYC),
		.BOOT_UNITS (BOOT_UNITS)
	) u_tick (
		.mclk      (mclk),
		.nrst      (nrst),
		.unit_tick (unit_tick),
		.phase     (phase),
		.boot      (boot)
	);

	led_serial_tx #(
		.HALF_CYC (SER_HALF_CYC)
	) u_ser (
		.mclk  (mclk),
		.nrst  (nrst),
		.en    (ser_en),
		.frame (ser_frame),
		.sdata (ser_data),
		.sclk  (ser_clk)
	);

	assign rate    = behav_ff[`LED_BH_RATE_LSB +: 2];
	assign split   = behav_ff[`LED_BH_SPLIT];
	assign str_sel = behav_ff[15:0];
	// Serial stream only from LED 0 of port 0
	assign ser_en  = (md[0] == led_pkg::MODE_SERIAL);

	// Per-LED mode, link vector and activity source
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			lk[p] = {link_10_cu[p], link_100_fi[p], link_100_cu[p],
				link_1g_fi[p], link_1g_cu[p]};
			fib[p] = link_100_fi[p] | link_1g_fi[p];
		end
		for (int i = 0; i < 16; i++) begin
			md[i] = led_pkg::led_mode_t'(mode_ff[i / 4][(i % 4) * 4 +: 4]);
			src[i] = act_src(md[i], split, tx_act[i / 4], rx_act[i / 4],
				collision[i / 4], fib[i / 4]);
		end
	end

	// Serial frame: 12 bits per port, port 0 first
	always_comb begin
		ser_frame = 48'h0;
		for (int p = 0; p < 4; p++) begin
			ser_frame[p * 12 + 0] = eval(led_pkg::MODE_LINK_ANY, lk[p],
				full_duplex[p], an_fault[p], tx_act[p] | rx_act[p],
				1'b0, phase[rate]);
			ser_frame[p * 12 + 1] = eval(led_pkg::MODE_LINK_1G, lk[p],
				full_duplex[p], an_fault[p], tx_act[p] | rx_act[p],
				1'b0, phase[rate]);
			ser_frame[p * 12 + 2] = eval(led_pkg::MODE_LINK_100, lk[p],
				full_duplex[p], an_fault[p], tx_act[p] | rx_act[p],
				1'b0, phase[rate]);
			ser_frame[p * 12 + 3] = eval(led_pkg::MODE_LINK_10, lk[p],
				full_duplex[p], an_fault[p], tx_act[p] | rx_act[p],
				1'b0, phase[rate]);
			ser_frame[p * 12 + 4] = eval(led_pkg::MODE_LINK_FIB, lk[p],
				full_duplex[p], an_fault[p], tx_act[p] | rx_act[p],
				1'b0, phase[rate]);
			ser_frame[p * 12 + 5] = eval(led_pkg::MODE_DUPLEX, lk[p],
				full_duplex[p], an_fault[p], collision[p],
				1'b0, phase[rate]);
			ser_frame[p * 12 + 6] = collision[p] & phase[rate];
			ser_frame[p * 12 + 7] = (tx_act[p] | rx_act[p]) & phase[rate];
			ser_frame[p * 12 + 8] = act_src(led_pkg::MODE_FIB_ACT, 1'b0,
				tx_act[p], rx_act[p], collision[p], fib[p]) & phase[rate];
			ser_frame[p * 12 + 9] = tx_act[p] & phase[rate];
			ser_frame[p * 12 + 10] = rx_act[p] & phase[rate];
			ser_frame[p * 12 + 11] = an_fault[p];
		end
	end

	// Stretch counters retrigger on activity, count down in 25 ms units
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			nxt_cnt_ff[i] = cnt_ff[i];
			if (src[i]) begin
				nxt_cnt_ff[i] = 5'h02 << rate;
			end else if (unit_tick && cnt_ff[i] != 5'h00) begin
				nxt_cnt_ff[i] = cnt_ff[i] - 5'h01;
			end
		end
	end

	// Logical state, then polarity and drive style on top
	always_comb begin
		nxt_state_ff = 16'h0;
		nxt_out_ff = 16'h0;
		nxt_oe_n_ff = 16'hffff;
		for (int i = 0; i < 16; i++) begin
			if (boot && behav_ff[`LED_BH_BOOT] &&
					md[i] != led_pkg::MODE_OFF &&
					md[i] != led_pkg::MODE_ON) begin
				nxt_state_ff[i] = phase[2];
			end else if (i == 0 || i == 1) begin
				// Port 0 LED 0 feeds the stream if it selects it
				nxt_state_ff[i] = eval(md[i], lk[0], full_duplex[0],
					an_fault[0], str_sel[i] ? (cnt_ff[i] != 5'h00) : src[i],
					str_sel[i], phase[rate]);
			end else begin
				nxt_state_ff[i] = eval(md[i], lk[i / 4],
					full_duplex[i / 4], an_fault[i / 4],
					str_sel[i] ? (cnt_ff[i] != 5'h00) : src[i],
					str_sel[i], phase[rate]);
			end
			if (nxt_state_ff[i]) begin
				nxt_out_ff[i] = drive_ff[i % 4];
				nxt_oe_n_ff[i] = 1'b0;
			end else begin
				nxt_out_ff[i] = ~drive_ff[i % 4];
				nxt_oe_n_ff[i] = drive_ff[`LED_DR_STYLE];
			end
		end
		// Stream takes LED0 and LED1 of port 0; others stay normal
		if (ser_en) begin
			nxt_out_ff[0] = ser_data;
			nxt_oe_n_ff[0] = 1'b0;
			nxt_out_ff[1] = ser_clk;
			nxt_oe_n_ff[1] = 1'b0;
		end
	end

	// Register writes
	always_comb begin
		nxt_mode_ff = mode_ff;
		nxt_behav_ff = behav_ff;
		nxt_drive_ff = drive_ff;
		if (reg_wr) begin
			case (reg_addr)
				`LED_OFF_MODE0: nxt_mode_ff[0] = reg_wdata[15:0];
				`LED_OFF_MODE1: nxt_mode_ff[1] = reg_wdata[15:0];
				`LED_OFF_MODE2: nxt_mode_ff[2] = reg_wdata[15:0];
				`LED_OFF_MODE3: nxt_mode_ff[3] = reg_wdata[15:0];
				`LED_OFF_BEHAV: nxt_behav_ff = reg_wdata[19:0];
				`LED_OFF_DRIVE: nxt_drive_ff = reg_wdata[4:0];
				default: ;
			endcase
		end
	end

	// Read data, zero for unmapped offsets and idle cycles
	always_comb begin
		nxt_rdata_ff = 32'h0;
		if (reg_rd) begin
			case (reg_addr)
				`LED_OFF_MODE0: nxt_rdata_ff = {16'h0, mode_ff[0]};
				`LED_OFF_MODE1: nxt_rdata_ff = {16'h0, mode_ff[1]};
				`LED_OFF_MODE2: nxt_rdata_ff = {16'h0, mode_ff[2]};
				`LED_OFF_MODE3: nxt_rdata_ff = {16'h0, mode_ff[3]};
				`LED_OFF_BEHAV: nxt_rdata_ff = {12'h0, behav_ff};
				`LED_OFF_DRIVE: nxt_rdata_ff = {27'h0, drive_ff};
				`LED_OFF_STAT: begin
					nxt_rdata_ff = {16'h0, state_ff};
					nxt_rdata_ff[`LED_ST_BOOT] = boot;
				end
				default: nxt_rdata_ff = 32'h0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int p = 0; p < 4; p++) begin
				mode_ff[p] <= `LED_MODE_RST;
			end
			behav_ff <= `LED_BEHAV_RST;
			drive_ff <= `LED_DRIVE_RST;
			rdata_ff <= 32'h0;
		end else begin
			mode_ff <= nxt_mode_ff;
			behav_ff <= nxt_behav_ff;
			drive_ff <= nxt_drive_ff;
			rdata_ff <= nxt_rdata_ff;
		end
	end

	// LED pipeline; pins idle tristated during reset
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 16; i++) begin
				cnt_ff[i] <= 5'h00;
			end
			state_ff <= 16'h0;
			out_ff <= 16'hffff;
			oe_n_ff <= 16'hffff;
		end else begin
			cnt_ff <= nxt_cnt_ff;
			state_ff <= nxt_state_ff;
			out_ff <= nxt_out_ff;
			oe_n_ff <= nxt_oe_n_ff;
		end
	end

	assign reg_rdata = rdata_ff;
	assign led_out   = out_ff;
	assign led_oe_n  = oe_n_ff;

endmodule : led_status_indicator

// File: dv/led_status_indicator_assertions.sv
// Checker for pin levels of the LED status indicator
`timescale 1ns/10ps
`include "led_cfg.svh"
module led_status_indicator_chk #(
	parameter int UNIT_CYC = 4
) (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        nrst,
	// Register writes
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	// Port status
	input wire logic [3:0]  link_1g_cu,
	input wire logic [3:0]  link_1g_fi,
	input wire logic [3:0]  link_100_cu,
	input wire logic [3:0]  link_100_fi,
	input wire logic [3:0]  link_10_cu,
	input wire logic [3:0]  full_duplex,
	input wire logic [3:0]  collision,
	input wire logic [3:0]  tx_act,
	input wire logic [3:0]  rx_act,
	input wire logic [3:0]  an_fault,
	// Pins
	input wire logic [15:0] led_out,
	input wire logic [15:0] led_oe_n
);
	localparam int QUIET = 41 * UNIT_CYC + 8;
	logic [15:0] mode_ff, nxt_mode, pol;
	logic [4:0]  drv_ff, nxt_drv;
	logic [1:0]  age_ff, nxt_age;
	int          up_ff, nxt_up;
	logic        ok, quiet, sty, fdl, act0, l1g;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	// Shadow of port0 modes and drive setup; age hides pipeline lag
	always_comb begin
		nxt_mode = mode_ff;
		nxt_drv  = drv_ff;
		nxt_age  = (age_ff == 2'h3) ? age_ff : age_ff + 2'h1;
		nxt_up   = (up_ff == QUIET) ? up_ff : up_ff + 1;
		if (reg_wr) begin
			nxt_age = 2'h0;
			if (reg_addr == `LED_OFF_MODE0)
				nxt_mode = reg_wdata[15:0];
			if (reg_addr == `LED_OFF_DRIVE)
				nxt_drv = reg_wdata[4:0];
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mode_ff <= `LED_MODE_RST;
			drv_ff  <= `LED_DRIVE_RST;
			age_ff  <= 2'h3;
			up_ff   <= 0;
		end else begin
			mode_ff <= nxt_mode;
			drv_ff  <= nxt_drv;
			age_ff  <= nxt_age;
			up_ff   <= nxt_up;
		end
	end

	// Derived conditions
	assign pol   = {4{drv_ff[3:0]}};
	assign sty   = drv_ff[4];
	assign ok    = age_ff == 2'h3;
	assign quiet = up_ff == QUIET;
	assign l1g   = link_1g_cu[0] | link_1g_fi[0];
	assign act0  = tx_act[0] | rx_act[0];
	assign fdl   = full_duplex[0] & (l1g | link_100_cu[0] |
		link_100_fi[0] | link_10_cu[0]);

	AST_TRI_LEVEL: assert property (
		ok && sty |-> led_out[15:2] == (pol[15:2] ^ led_oe_n[15:2])
	) else $error("pin level does not match its enable");
	AST_DRIVE_ALL: assert property (
		ok && !sty |-> led_oe_n == 16'h0000
	) else $error("pin released with driven idle style");
	AST_FORCE_ON: assert property (
		ok && mode_ff[15:12] == 4'hf |-> !led_oe_n[3] &&
			led_out[3] == drv_ff[3]
	) else $error("forced-on LED not lit");
	AST_FORCE_OFF: assert property (
		ok && mode_ff[15:12] == 4'he |-> led_oe_n[3] == sty &&
			led_out[3] == !drv_ff[3]
	) else $error("forced-off LED not dark");
	AST_AN_FAULT: assert property (
		ok && quiet && mode_ff[11:8] == 4'hc |->
			led_out[2] == (drv_ff[2] ^ !$past(an_fault[0]))
	) else $error("fault LED does not follow fault input");
	AST_LINK_1G: assert property (
		ok && quiet && mode_ff[7:4] == 4'h1 && mode_ff[3:0] != 4'hd &&
			!$past(act0) |-> led_out[1] == (drv_ff[1] ^ !$past(l1g))
	) else $error("gigabit LED does not follow link");
	AST_DUPLEX: assert property (
		ok && quiet && mode_ff[15:12] == 4'h8 && !$past(collision[0])
			|-> led_out[3] == (drv_ff[3] ^ !$past(fdl))
	) else $error("duplex LED does not follow full duplex");
	AST_SER_DRIVEN: assert property (
		ok && mode_ff[3:0] == 4'hd |-> led_oe_n[1:0] == 2'b00
	) else $error("stream pins not driven");
	AST_SER_DATA: assert property (
		ok && mode_ff[3:0] == 4'hd && $changed(led_out[0]) |-> !led_out[1]
	) else $error("stream data moved while clock high");
endmodule : led_status_indicator_chk

bind led_status_indicator led_status_indicator_chk #(
	.UNIT_CYC(UNIT_CYC)
) u_chk (
	.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .link_1g_cu(link_1g_cu),
	.link_1g_fi(link_1g_fi), .link_100_cu(link_100_cu),
	.link_100_fi(link_100_fi), .link_10_cu(link_10_cu),
	.full_duplex(full_duplex), .collision(collision), .tx_act(tx_act),
	.rx_act(rx_act), .an_fault(an_fault), .led_out(led_out),
	.led_oe_n(led_oe_n)
);

// File: dv/led_panel.sv
// LED loads hung on the sixteen indicator pins
`timescale 1ns/10ps
module led_panel (
	// Pin side
	input  wire logic [15:0] led_out,
	input  wire logic [15:0] led_oe_n,
	// Board wiring per LED index, 1 = LED to ground
	input  wire logic [3:0]  pol,
	// Seen light
	output logic      [15:0] lit
);
	logic [15:0] pw;
	logic [15:0] lvl;
	// Released pin sits at the far end of its LED, so it stays dark
	assign pw  = {4{pol}};
	assign lvl = (~led_oe_n & led_out) | (led_oe_n & ~pw);
	// Current flows only at the active level
	assign lit = ~(lvl ^ pw);
endmodule : led_panel

// File: dv/tb_top.sv
// Self-checking bench for the LED status indicator
`timescale 1ns/10ps
`include "led_cfg.svh"
module tb_top;
	localparam int U = 4;
	logic        mclk, nrst, reg_wr, reg_rd;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [47:0] fr;
	logic [3:0]  link_1g_cu, link_1g_fi, link_100_cu, link_100_fi;
	logic [3:0]  link_10_cu, full_duplex, collision, tx_act, rx_act;
	logic [3:0]  an_fault, pol;
	logic [15:0] led_out, led_oe_n, lit;
	logic [4:0]  lmask [8] = '{5'h1f, 5'h03, 5'h0c, 5'h10, 5'h0f,
		5'h13, 5'h1c, 5'h0a};
	int          miscompares, tests_run, n;

	// Clock
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;

	led_status_indicator #(.UNIT_CYC(U), .SER_HALF_CYC(2))
	u_led_status_indicator (
		.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .link_1g_cu(link_1g_cu),
		.link_1g_fi(link_1g_fi), .link_100_cu(link_100_cu),
		.link_100_fi(link_100_fi), .link_10_cu(link_10_cu),
		.full_duplex(full_duplex), .collision(collision),
		.tx_act(tx_act), .rx_act(rx_act), .an_fault(an_fault),
		.led_out(led_out), .led_oe_n(led_oe_n));
	led_panel u_led_panel (.led_out(led_out), .led_oe_n(led_oe_n),
		.pol(pol), .lit(lit));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("compares %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	// Register port cycles; read data is taken in the cycle after
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		v = reg_rdata;
	endtask : rd
	task automatic links(input logic [4:0] k);
		@(posedge mclk);
		link_1g_cu  <= {4{k[0]}};
		link_1g_fi  <= {4{k[1]}};
		link_100_cu <= {4{k[2]}};
		link_100_fi <= {4{k[3]}};
		link_10_cu  <= {4{k[4]}};
	endtask : links
	task automatic set_modes(input logic [3:0] m);
		for (int p = 0; p < 4; p++)
			wr(8'(4 * p), {16'h0000, {4{m}}});
	endtask : set_modes
	// Same mode on all sixteen LEDs, state read back and seen lit
	task automatic all_modes(input logic [3:0] m, input logic e);
		set_modes(m);
		repeat (4) @(posedge mclk);
		rd(`LED_OFF_STAT);
		chk(v[15:0], {16{e}});
		chk(lit, {16{e}});
	endtask : all_modes
	task automatic count_on(input int i, input int cyc);
		n = 0;
		repeat (cyc) begin
			@(negedge mclk);
			if (lit[i] === 1'b1)
				n++;
		end
	endtask : count_on
	// Far-side shift register: one frame, bit taken at stream clock rise
	task automatic grab_frame(output logic [47:0] f);
		logic prev;
		int   b;
		prev = 1'b1;
		b = 0;
		f = 48'h0;
		while (b < 48) begin
			@(negedge mclk);
			if (!prev && led_out[1]) begin
				f = {led_out[0], f[47:1]};
				b++;
			end
			prev = led_out[1];
		end
	endtask : grab_frame
	// Window of four blink periods; lit count must equal e, exactly half while blinking
	task automatic act_case(input logic [3:0] m,
		input logic [31:0] b, input int e);
		wr(`LED_OFF_BEHAV, b);
		set_modes(m);
		repeat (2 * U) @(posedge mclk);
		// Four periods of the selected rate, so the count is exact
		count_on(0, (8 * U) << b[17:16]);
		chk(n, e);
	endtask : act_case

	// Watchdog, far beyond the few thousand cycles needed
	initial begin
		#200000;
		miscompares++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		{nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{link_1g_cu, link_1g_fi, link_100_cu, link_100_fi} = '0;
		{link_10_cu, full_duplex, collision, tx_act, rx_act} = '0;
		{an_fault, pol, miscompares, tests_run} = '0;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		rd(`LED_OFF_MODE0);
		chk(v, 32'h00008210);
		rd(`LED_OFF_BEHAV);
		chk(v, 32'h00080000);
		rd(`LED_OFF_DRIVE);
		chk(v, 32'h00000010);
		rd(8'h1c);
		chk(v, 32'h00000000);
		wr(`LED_OFF_MODE0, 32'h0000fe10);
		count_on(0, 32);
		chk(n, 16);
		count_on(3, 16);
		chk(n, 16);
		count_on(2, 16);
		chk(n, 0);
		$display("test after-reset done");
		repeat (45 * U) @(posedge mclk);
		rd(`LED_OFF_STAT);
		chk(v[16], 1'b0);
		for (int k = 0; k < 6; k++) begin
			links(5'(1 << k));
			for (int m = 0; m < 8; m++)
				all_modes(4'(m), k < 5 && lmask[m][k]);
		end
		$display("test link modes done");
		links(5'h01);
		@(posedge mclk) full_duplex <= 4'hf;
		all_modes(4'h8, 1'b1);
		@(posedge mclk) full_duplex <= 4'h0;
		all_modes(4'h8, 1'b0);
		all_modes(4'h9, 1'b0);
		all_modes(4'hc, 1'b0);
		@(posedge mclk) an_fault <= 4'hf;
		all_modes(4'hc, 1'b1);
		all_modes(4'he, 1'b0);
		all_modes(4'hf, 1'b1);
		all_modes(4'ha, 1'b0);
		all_modes(4'hb, 1'b0);
		$display("test steady modes done");
		all_modes(4'h0, 1'b1);
		@(posedge mclk) tx_act <= 4'hf;
		for (int r = 0; r < 4; r++)
			act_case(4'h0, 32'(r << 16), 4 * (U << r));
		@(posedge mclk) tx_act <= 4'h0;
		@(posedge mclk) rx_act <= 4'hf;
		act_case(4'ha, 32'h00000000, 4 * U);
		act_case(4'ha, 32'h00040000, 0);
		act_case(4'hb, 32'h00040000, 4 * U);
		act_case(4'hb, 32'h00000000, 0);
		@(posedge mclk) collision <= 4'hf;
		act_case(4'h9, 32'h00000000, 4 * U);
		act_case(4'h8, 32'h00000000, 4 * U);
		@(posedge mclk) collision <= 4'h0;
		@(posedge mclk) rx_act <= 4'h0;
		act_case(4'ha, 32'h0000ffff, 0);
		@(posedge mclk) tx_act <= 4'hf;
		@(posedge mclk) tx_act <= 4'h0;
		count_on(0, 8 * U);
		chk(32'(n >= U && n <= 2 * U + 2), 32'h1);
		$display("test activity done");
		wr(`LED_OFF_BEHAV, 32'h00000000);
		wr(`LED_OFF_DRIVE, 32'h00000000);
		all_modes(4'h1, 1'b1);
		all_modes(4'h2, 1'b0);
		chk(led_oe_n, 16'h0000);
		chk(led_out, 16'hffff);
		wr(`LED_OFF_DRIVE, 32'h0000001f);
		@(posedge mclk) pol <= 4'hf;
		all_modes(4'h1, 1'b1);
		chk(led_out, 16'hffff);
		$display("test drive done");
		links(5'h04);
		wr(`LED_OFF_MODE0, 32'h0000821d);
		wr(`LED_OFF_MODE1, 32'h0000000d);
		repeat (10) @(posedge mclk);
		rd(`LED_OFF_STAT);
		chk(v[4], 1'b0);
		chk(v[2], 1'b1);
		chk(led_oe_n[1:0], 2'b00);
		count_on(1, 40);
		chk(32'(n > 0 && n < 40), 32'h1);
		// Restart the stream so the capture begins on frame bit 0
		wr(`LED_OFF_MODE0, 32'h00008210);
		@(posedge mclk) an_fault <= 4'h5;
		wr(`LED_OFF_MODE0, 32'h0000821d);
		grab_frame(fr);
		chk(fr[31:0], 32'h05005805);
		chk(32'(fr[47:32]), 32'h00000058);
		$display("test serial done");
		report_and_stop();
	end
endmodule : tb_top
